// [logic/tsro_pkg.sv]
// Overview of operation
// - a stage starts while measured current exceeds its start level
// - start output and yellow indicator come on in the same cycle
// - started longer than operate time gives trip, indicator turns red
// - each of the four indicators has its own self or manual mode
// - self-reset indicator goes dark as soon as its stage resets
// - manual indicators clear by front reset or either remote reset
// - low-set blocking input keeps the low-set trip output off
// - high-set blocking input keeps the high-set stage from starting
// - blocking inputs come from external lines via routing switches
// - routing switches pick which starts drive the reclose outputs
// - two front switches pick one of three low-set level ranges
// - one front switch picks the low-set operate time range
// - two front switches pick one of three high-set level ranges
// - one front switch picks the high-set operate time range
// - infinite high-set level disables the high-set stage entirely
// - with latching on, a trip output holds after its cause ends
// - latched trips release on step plus reset or a remote reset
// - manual indicator stays lit after its stage resets until cleared
// - indicator state never affects starting or operating
package tsro_pkg;
	localparam int CUR_W  = 16;	// current in 0.01 % of rated
	localparam int TIME_W = 11;	// operate time in 10 ms ticks
	localparam int SYNC_W = 25;

	localparam int CLK_KHZ     = 250000;
	localparam int TICK_MS     = 10;
	localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
	localparam int LONG_SCALE  = 10;

	// low-set setting is in 0.01 %, high-set setting in 0.1 %
	localparam logic [7:0] LOW_MULT_0  = 8'h01;
	localparam logic [7:0] LOW_MULT_1  = 8'h05;
	localparam logic [7:0] LOW_MULT_2  = 8'h19;
	localparam logic [7:0] HIGH_MULT_0 = 8'h0A;
	localparam logic [7:0] HIGH_MULT_1 = 8'h32;
	localparam logic [7:0] HIGH_MULT_2 = 8'hFA;
	localparam logic [7:0] HIGH_INFINITE = 8'hFF;

	// front switch positions
	localparam int SW_LOW_TIME   = 0;
	localparam int SW_LOW_LEVEL  = 1;
	localparam int SW_LATCH      = 3;
	localparam int SW_HIGH_LEVEL = 5;
	localparam int SW_HIGH_TIME  = 7;

	// indicator mode bits, 1 = manual reset
	localparam int IND_LOW_START  = 0;
	localparam int IND_LOW_OP     = 1;
	localparam int IND_HIGH_START = 2;
	localparam int IND_HIGH_OP    = 3;

	// routing switch positions
	localparam int RT_LOW_BLOCK  = 0;
	localparam int RT_HIGH_BLOCK = 3;
	localparam int RT_RECLOSE_A  = 6;
	localparam int RT_RECLOSE_B  = 7;

	localparam logic [SYNC_W-1:0] SYNC_RST = 25'h0000000;
	localparam logic [3:0]        IND_RST  = 4'h0;

	typedef struct packed {
		logic       step_btn;
		logic       reset_btn;
		logic [7:0] routing;
		logic [3:0] ind_mode;
		logic [7:0] front;
		logic [2:0] ext_lines;
	} tsro_pins_t;
endpackage

// [logic/tsro_stage.sv]
`timescale 1ns/1ps
module tsro_stage (
	input  wire logic                     mclk,          // system clock
	input  wire logic                     rst_n,         // async reset
	input  wire logic                     tick,          // 10 ms enable
	input  wire logic                     over,          // current > level
	input  wire logic                     start_block,   // no start
	input  wire logic                     operate_block, // no trip
	input  wire logic [tsro_pkg::TIME_W-1:0] target,     // operate ticks
	input  wire logic                     latch_en,      // hold trips
	input  wire logic                     latch_clr,     // release latch
	output logic                          start_soon,    // next start
	output logic                          trip_soon,     // next trip
	output logic                          start_out,     // start state
	output logic                          trip_out       // trip state
);
	logic [tsro_pkg::TIME_W-1:0] count_reg;
	logic [tsro_pkg::TIME_W-1:0] count_next;
	logic                        reached;
	logic                        fresh;

	assign reached = count_reg >= target;

	always_comb begin
		start_soon = over && !start_block;
		count_next = count_reg;
		if (!start_soon)
			count_next = '0;
		else if (tick && !reached)
			count_next = count_reg + 1'b1;
		fresh = start_soon && reached;
		if (operate_block)
			trip_soon = 1'b0;
		else if (latch_en)
			trip_soon = fresh || (trip_out && !latch_clr);
		else
			trip_soon = fresh;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			start_out <= 1'b0;
			trip_out  <= 1'b0;
		end else begin
			start_out <= start_soon;
			trip_out  <= trip_soon;
		end
	end

	sequence held_latch_s;
		trip_out && latch_en && !latch_clr && !operate_block;
	endsequence

	start_on_over_a: assert property (@(posedge mclk) disable iff (!rst_n)
		over && !start_block |=> start_out)
		else $error("stage did not start on overcurrent");
	drop_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!over |=> !start_out && count_reg == '0)
		else $error("start or timer kept after current fell");
	op_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
		operate_block |=> !trip_out)
		else $error("trip while operation blocked");
	trip_needs_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!latch_en && !start_out |-> !trip_out)
		else $error("unlatched trip without start");
	latch_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
		held_latch_s ##1 !operate_block |-> trip_out)
		else $error("latched trip dropped");
	timer_trip_a: assert property (@(posedge mclk) disable iff (!rst_n)
		start_soon && reached && !operate_block |=> trip_out)
		else $error("no trip after operate time");
endmodule

// [logic/tsro_top.sv]
`timescale 1ns/1ps
module tsro_top #(
	parameter int TICK_CYCLES = tsro_pkg::TICK_CYCLES
) (
	input  wire logic                       mclk,               // 250 MHz
	input  wire logic                       rst_n,              // async
	input  wire logic [tsro_pkg::CUR_W-1:0] energizing_current, // 0.01 %
	input  wire logic [7:0]                 low_level_setting,  // 0.01 %
	input  wire logic [7:0]                 high_level_setting, // 0.1 %
	input  wire logic [6:0]                 low_time_setting,   // 10 ms
	input  wire logic [6:0]                 high_time_setting,  // 10 ms
	input  wire logic                       ext_block_line_a,   // pin
	input  wire logic                       ext_block_line_b,   // pin
	input  wire logic                       ext_block_line_c,   // pin
	input  wire logic [7:0]                 front_range_switches,    // pins
	input  wire logic [3:0]                 indicator_mode_switches, // pins
	input  wire logic [7:0]                 block_routing_switches,  // pins
	input  wire logic                       step_button,        // pin
	input  wire logic                       reset_button,       // pin
	input  wire logic                       remote_reset_a,     // pulse
	input  wire logic                       remote_reset_b,     // pulse
	output logic                            low_stage_start_out,  // start
	output logic                            high_stage_start_out, // start
	output logic                            low_stage_trip_out,   // trip
	output logic                            high_stage_trip_out,  // trip
	output logic                            reclose_start_a,    // to reclose
	output logic                            reclose_start_b,    // to reclose
	output logic                            low_yellow_led,     // started
	output logic                            low_red_led,        // operated
	output logic                            high_yellow_led,    // started
	output logic                            high_red_led        // operated
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	logic [tsro_pkg::SYNC_W-1:0] sync1_reg;
	logic [tsro_pkg::SYNC_W-1:0] sync2_reg;
	logic [tsro_pkg::SYNC_W-1:0] sync3_reg;
	logic [tsro_pkg::SYNC_W-1:0] stable_reg;
	tsro_pkg::tsro_pins_t        pins;
	logic [TICK_W-1:0]           div_reg;
	logic                        tick_reg;
	logic                        low_operate_block;
	logic                        high_start_block;
	logic                        high_disable;
	logic [tsro_pkg::CUR_W-1:0]  low_level;
	logic [tsro_pkg::CUR_W-1:0]  high_level;
	logic [tsro_pkg::TIME_W-1:0] low_target;
	logic [tsro_pkg::TIME_W-1:0] high_target;
	logic                        low_over;
	logic                        high_over;
	logic                        ind_clr;
	logic                        latch_clr;
	logic                        low_start_soon;
	logic                        low_trip_soon;
	logic                        high_start_soon;
	logic                        high_trip_soon;
	logic [3:0]                  ind_set;
	logic [3:0]                  ind_reg;
	logic [3:0]                  ind_next;

	function automatic logic [tsro_pkg::CUR_W-1:0] level_of(
		input logic [7:0] setting,
		input logic [1:0] range,
		input logic [7:0] m0,
		input logic [7:0] m1,
		input logic [7:0] m2
	);
		logic [7:0] mult;
		mult = (range == 2'h0) ? m0 : ((range == 2'h1) ? m1 : m2);
		return tsro_pkg::CUR_W'(setting) * tsro_pkg::CUR_W'(mult);
	endfunction

	function automatic logic [tsro_pkg::TIME_W-1:0] ticks_of(
		input logic [6:0] setting,
		input logic       long_range
	);
		logic [tsro_pkg::TIME_W-1:0] base;
		base = tsro_pkg::TIME_W'(setting);
		return long_range ? tsro_pkg::TIME_W'(base * tsro_pkg::LONG_SCALE)
		                  : base;
	endfunction

	// pins settle through three flops; a change counts once two agree
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg  <= tsro_pkg::SYNC_RST;
			sync2_reg  <= tsro_pkg::SYNC_RST;
			sync3_reg  <= tsro_pkg::SYNC_RST;
			stable_reg <= tsro_pkg::SYNC_RST;
		end else begin
			sync1_reg <= {step_button, reset_button, block_routing_switches,
			              indicator_mode_switches, front_range_switches,
			              ext_block_line_c, ext_block_line_b,
			              ext_block_line_a};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg)
				stable_reg <= sync3_reg;
		end
	end

	assign pins = tsro_pkg::tsro_pins_t'(stable_reg);

	// one 10 ms enable serves both operate timers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (div_reg == TICK_W'(TICK_CYCLES - 1)) begin
			div_reg  <= '0;
			tick_reg <= 1'b1;
		end else begin
			div_reg  <= div_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// any enabled external line blocks the stage it is routed to
	assign low_operate_block = |(pins.ext_lines &
		pins.routing[tsro_pkg::RT_LOW_BLOCK +: 3]);
	assign high_start_block = |(pins.ext_lines &
		pins.routing[tsro_pkg::RT_HIGH_BLOCK +: 3]) | high_disable;

	assign low_level = level_of(low_level_setting,
		pins.front[tsro_pkg::SW_LOW_LEVEL +: 2], tsro_pkg::LOW_MULT_0,
		tsro_pkg::LOW_MULT_1, tsro_pkg::LOW_MULT_2);
	assign high_level = level_of(high_level_setting,
		pins.front[tsro_pkg::SW_HIGH_LEVEL +: 2], tsro_pkg::HIGH_MULT_0,
		tsro_pkg::HIGH_MULT_1, tsro_pkg::HIGH_MULT_2);
	assign high_disable = high_level_setting == tsro_pkg::HIGH_INFINITE;

	assign low_target = ticks_of(low_time_setting,
		pins.front[tsro_pkg::SW_LOW_TIME]);
	assign high_target = ticks_of(high_time_setting,
		pins.front[tsro_pkg::SW_HIGH_TIME]);

	assign low_over  = energizing_current > low_level;
	assign high_over = energizing_current > high_level && !high_disable;

	assign ind_clr   = pins.reset_btn | remote_reset_a | remote_reset_b;
	assign latch_clr = (pins.step_btn & pins.reset_btn) |
	                   remote_reset_a | remote_reset_b;

	// indicators only watch the stages; nothing feeds back into them
	tsro_stage u_low (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.tick          (tick_reg),
		.over          (low_over),
		.start_block   (1'b0),
		.operate_block (low_operate_block),
		.target        (low_target),
		.latch_en      (pins.front[tsro_pkg::SW_LATCH]),
		.latch_clr     (latch_clr),
		.start_soon    (low_start_soon),
		.trip_soon     (low_trip_soon),
		.start_out     (low_stage_start_out),
		.trip_out      (low_stage_trip_out)
	);

	tsro_stage u_high (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.tick          (tick_reg),
		.over          (high_over),
		.start_block   (high_start_block),
		.operate_block (high_disable),
		.target        (high_target),
		.latch_en      (pins.front[tsro_pkg::SW_LATCH]),
		.latch_clr     (latch_clr),
		.start_soon    (high_start_soon),
		.trip_soon     (high_trip_soon),
		.start_out     (high_stage_start_out),
		.trip_out      (high_stage_trip_out)
	);

	// set wins over clear so a start seen during a reset is not lost
	assign ind_set = {high_trip_soon, high_start_soon,
	                  low_trip_soon, low_start_soon};

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pins.ind_mode[i])
				ind_next[i] = ind_set[i] | (ind_reg[i] & !ind_clr);
			else
				ind_next[i] = ind_set[i];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			ind_reg <= tsro_pkg::IND_RST;
		else
			ind_reg <= ind_next;
	end

	// red overrides yellow on the shared two-colour lamp
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_yellow_led  <= 1'b0;
			low_red_led     <= 1'b0;
			high_yellow_led <= 1'b0;
			high_red_led    <= 1'b0;
		end else begin
			low_yellow_led  <= ind_next[tsro_pkg::IND_LOW_START] &&
			                   !ind_next[tsro_pkg::IND_LOW_OP];
			low_red_led     <= ind_next[tsro_pkg::IND_LOW_OP];
			high_yellow_led <= ind_next[tsro_pkg::IND_HIGH_START] &&
			                   !ind_next[tsro_pkg::IND_HIGH_OP];
			high_red_led    <= ind_next[tsro_pkg::IND_HIGH_OP];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reclose_start_a <= 1'b0;
			reclose_start_b <= 1'b0;
		end else begin
			reclose_start_a <= pins.routing[tsro_pkg::RT_RECLOSE_A] ?
			                   high_start_soon : low_start_soon;
			reclose_start_b <= pins.routing[tsro_pkg::RT_RECLOSE_B] ?
			                   low_start_soon : high_start_soon;
		end
	end

	// a clear in the trip cycle itself may legally drop the lamp
	sequence low_op_s;
		low_stage_trip_out && pins.ind_mode[tsro_pkg::IND_LOW_OP] &&
		!ind_clr;
	endsequence

	sequence no_clear_s;
		!ind_clr;
	endsequence

	yellow_with_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
		low_stage_start_out && !low_red_led |-> low_yellow_led)
		else $error("low start without yellow lamp");
	red_with_trip_a: assert property (@(posedge mclk) disable iff (!rst_n)
		high_stage_trip_out |-> high_red_led && !high_yellow_led)
		else $error("high trip without red lamp");
	manual_red_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
		low_op_s ##1 no_clear_s |=> low_red_led)
		else $error("manual red lamp dropped without reset");
	self_reset_dark_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!pins.ind_mode[tsro_pkg::IND_HIGH_START] &&
		!pins.ind_mode[tsro_pkg::IND_HIGH_OP] && !high_stage_start_out
		|-> !high_yellow_led && !high_red_led)
		else $error("self-reset lamp lit after stage reset");
	manual_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ind_clr && !low_start_soon && !low_trip_soon |=> !low_yellow_led
		&& !low_red_led)
		else $error("manual lamp not cleared by reset");
	high_infinite_a: assert property (@(posedge mclk) disable iff (!rst_n)
		high_disable |=> !high_stage_start_out && !high_stage_trip_out)
		else $error("high stage active while set infinite");
	high_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
		|(pins.ext_lines & pins.routing[tsro_pkg::RT_HIGH_BLOCK +: 3])
		|=> !high_stage_start_out)
		else $error("high stage started while blocked");
	reclose_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!pins.routing[tsro_pkg::RT_RECLOSE_A] |->
		reclose_start_a == low_stage_start_out)
		else $error("reclose start a not following low start");
	latch_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
		remote_reset_a && !low_trip_soon |=> !low_stage_trip_out)
		else $error("latched low trip not released by remote reset");
endmodule

// [test/tsro_field_model.sv]
`timescale 1ns/1ps
// stands in for the current measurement, blocking wiring and serial master
module tsro_field_model (
	input  wire logic                   mclk,               // clock
	output logic [tsro_pkg::CUR_W-1:0]  energizing_current, // 0.01 %
	output logic                        ext_block_line_a,   // line a
	output logic                        ext_block_line_b,   // line b
	output logic                        ext_block_line_c,   // line c
	output logic                        remote_reset_a,     // pulse
	output logic                        remote_reset_b      // pulse
);
	initial begin
		energizing_current = '0;
		{ext_block_line_c, ext_block_line_b, ext_block_line_a} = 3'h0;
		remote_reset_a = 1'b0;
		remote_reset_b = 1'b0;
	end

	task automatic drive_current(input logic [tsro_pkg::CUR_W-1:0] v);
		@(posedge mclk);
		energizing_current <= v;
	endtask

	task automatic drive_lines(input logic [2:0] v);
		@(posedge mclk);
		{ext_block_line_c, ext_block_line_b, ext_block_line_a} <= v;
	endtask

	// serial commands arrive as single-cycle pulses, never overlapping
	task automatic send_remote(input logic sel);
		@(posedge mclk);
		remote_reset_a <= !sel;
		remote_reset_b <= sel;
		@(posedge mclk);
		remote_reset_a <= 1'b0;
		remote_reset_b <= 1'b0;
	endtask
endmodule

// [test/tsro_top_tb.sv]
`timescale 1ns/1ps
module tsro_top_tb;
	localparam int TICK  = 4;
	localparam int LIMIT = 20000;
	logic                 mclk;
	logic                 rst_n;
	tsro_pkg::tsro_pins_t pins;
	logic [7:0]           low_lvl;
	logic [7:0]           high_lvl;
	logic [6:0]           low_tm;
	logic [6:0]           high_tm;
	logic [15:0]          cur;
	logic                 lb_a, lb_b, lb_c, rr_a, rr_b;
	logic                 ls, hs, lt, ht, ra, rb, ly, lr, hy, hr;
	int                   errors;
	int                   checked;
	int                   cycles;
	int                   ml[3] = '{1, 5, 25};
	int                   mh[3] = '{10, 50, 250};

	tsro_field_model field (.mclk(mclk), .energizing_current(cur),
		.ext_block_line_a(lb_a), .ext_block_line_b(lb_b),
		.ext_block_line_c(lb_c), .remote_reset_a(rr_a),
		.remote_reset_b(rr_b));

	// short tick keeps the 10 ms timer steps at a few cycles each
	tsro_top #(.TICK_CYCLES(TICK)) dut (.mclk(mclk), .rst_n(rst_n),
		.energizing_current(cur), .low_level_setting(low_lvl),
		.high_level_setting(high_lvl), .low_time_setting(low_tm),
		.high_time_setting(high_tm), .ext_block_line_a(lb_a),
		.ext_block_line_b(lb_b), .ext_block_line_c(lb_c),
		.front_range_switches(pins.front),
		.indicator_mode_switches(pins.ind_mode),
		.block_routing_switches(pins.routing),
		.step_button(pins.step_btn), .reset_button(pins.reset_btn),
		.remote_reset_a(rr_a), .remote_reset_b(rr_b),
		.low_stage_start_out(ls), .high_stage_start_out(hs),
		.low_stage_trip_out(lt), .high_stage_trip_out(ht),
		.reclose_start_a(ra), .reclose_start_b(rb),
		.low_yellow_led(ly), .low_red_led(lr),
		.high_yellow_led(hy), .high_red_led(hr));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == LIMIT) begin
			errors = errors + 1;
			$display("ERROR at %0t: run did not finish", $time);
			print_verdict();
		end
	end

	task automatic check(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: %s read %b", $time, m, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic set_lvl(input logic [7:0] l, input logic [7:0] h,
		input logic [6:0] lt_v, input logic [6:0] ht_v);
		@(posedge mclk);
		low_lvl <= l;
		high_lvl <= h;
		low_tm <= lt_v;
		high_tm <= ht_v;
	endtask

	// switches pass a synchroniser, so give them time to land
	task automatic set_sw(input logic [7:0] f, input logic [3:0] ind,
		input logic [7:0] rt);
		@(posedge mclk);
		pins.front <= f;
		pins.ind_mode <= ind;
		pins.routing <= rt;
		cyc(6);
	endtask

	task automatic press(input logic step);
		@(posedge mclk);
		pins.step_btn <= step;
		pins.reset_btn <= 1'b1;
		cyc(6);
		@(posedge mclk);
		pins.step_btn <= 1'b0;
		pins.reset_btn <= 1'b0;
	endtask

	task automatic wait_trip(input logic high, input int lo, input int hi);
		int c;
		c = 0;
		while ((high ? ht : lt) !== 1'b1 && c <= hi) begin
			@(posedge mclk);
			#1;
			c++;
		end
		checked++;
		if (c < lo || c > hi) begin
			errors++;
			$display("ERROR at %0t: trip after %0d cycles", $time, c);
		end
	endtask

	initial begin
		errors = 0;
		checked = 0;
		cycles = 0;
		rst_n = 1'b0;
		pins = '0;
		low_lvl = 8'h64;
		high_lvl = 8'h14;
		low_tm = 7'h05;
		high_tm = 7'h0A;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(6);

		field.drive_current(16'h0064);
		cyc(6);
		check(ls, 1'b0, "start at level");
		field.drive_current(16'h0065);
		cyc(2);
		check(ls, 1'b1, "low start");
		check(ly, 1'b1, "low yellow");
		check(ra, 1'b1, "reclose a low");
		check(hs, 1'b0, "high start below level");
		field.drive_current(16'h0000);
		cyc(2);
		check(ls, 1'b0, "start drop");
		check(ly, 1'b0, "yellow self reset");
		$display("start test done");

		field.drive_current(16'h00FF);
		wait_trip(1'b0, 4 * TICK, 5 * TICK + 6);
		check(lr, 1'b1, "low red");
		check(ly, 1'b0, "low yellow on trip");
		check(hy, 1'b1, "high yellow");
		wait_trip(1'b1, 10, 30);
		check(hr, 1'b1, "high red");
		check(hy, 1'b0, "high yellow on trip");
		field.drive_current(16'h0000);
		cyc(2);
		check(lt, 1'b0, "low trip drop");
		check(ht, 1'b0, "high trip drop");
		check(lr, 1'b0, "red self reset");
		$display("timer test done");

		set_sw(8'h00, 4'hF, 8'h00);
		for (int k = 0; k < 3; k++) begin
			field.drive_current(16'h0065);
			wait_trip(1'b0, 4 * TICK, 5 * TICK + 6);
			field.drive_current(16'h0000);
			cyc(5);
			check(lr, 1'b1, "manual red held");
			field.drive_current(16'h0065);
			wait_trip(1'b0, 4 * TICK, 5 * TICK + 6);
			field.drive_current(16'h0000);
			cyc(2);
			if (k == 2)
				press(1'b0);
			else
				field.send_remote(k[0]);
			cyc(6);
			check(lr, 1'b0, "manual red cleared");
		end
		set_sw(8'h00, 4'h1, 8'h00);
		field.drive_current(16'h0065);
		cyc(3);
		field.drive_current(16'h0000);
		cyc(3);
		check(ly, 1'b1, "manual yellow held");
		field.drive_current(16'h0065);
		wait_trip(1'b0, 4 * TICK, 5 * TICK + 6);
		field.drive_current(16'h0000);
		cyc(3);
		check(lr, 1'b0, "self red beside manual yellow");
		field.send_remote(1'b0);
		$display("indicator test done");

		set_sw(8'h08, 4'h0, 8'h00);
		for (int k = 0; k < 2; k++) begin
			field.drive_current(16'h0065);
			wait_trip(1'b0, 4 * TICK, 5 * TICK + 6);
			field.drive_current(16'h0000);
			cyc(5);
			check(lt, 1'b1, "latched trip");
			if (k == 0)
				press(1'b1);
			else
				field.send_remote(1'b1);
			cyc(6);
			check(lt, 1'b0, "latch released");
		end
		$display("latch test done");

		for (int i = 0; i < 3; i++) begin
			set_sw(8'h00, 4'h0, 8'(8'h09 << i));
			field.drive_lines(3'(1 << i));
			cyc(6);
			field.drive_current(16'h00FF);
			cyc(40);
			check(ls, 1'b1, "blocked low starts");
			check(lt, 1'b0, "blocked low trip");
			check(hs, 1'b0, "blocked high start");
			check(ht, 1'b0, "blocked high trip");
			field.drive_current(16'h0000);
			field.drive_lines(3'h0);
		end
		set_sw(8'h00, 4'h0, 8'h00);
		field.drive_lines(3'h7);
		cyc(6);
		field.drive_current(16'h00FF);
		cyc(3);
		check(hs, 1'b1, "unrouted lines ignored");
		check(rb, 1'b1, "reclose b high");
		field.drive_current(16'h0000);
		field.drive_lines(3'h0);
		set_sw(8'h00, 4'h0, 8'hC0);
		field.drive_current(16'h0096);
		cyc(3);
		check(ra, 1'b0, "reclose a high");
		check(rb, 1'b1, "reclose b low");
		field.drive_current(16'h0000);
		$display("blocking test done");

		set_lvl(8'h04, 8'h02, 7'h05, 7'h0A);
		for (int r = 0; r < 3; r++) begin
			set_sw({1'b0, 2'(r), 2'b00, 2'(r), 1'b0}, 4'h0, 8'h00);
			field.drive_current(16'(4 * ml[r]));
			cyc(3);
			check(ls, 1'b0, "low range at level");
			field.drive_current(16'(4 * ml[r] + 1));
			cyc(3);
			check(ls, 1'b1, "low range above");
			field.drive_current(16'(2 * mh[r]));
			cyc(3);
			check(hs, 1'b0, "high range at level");
			field.drive_current(16'(2 * mh[r] + 1));
			cyc(3);
			check(hs, 1'b1, "high range above");
			field.drive_current(16'h0000);
			cyc(3);
		end
		set_lvl(8'h04, 8'hFF, 7'h05, 7'h0A);
		field.drive_current(16'hFFFF);
		cyc(60);
		check(hs, 1'b0, "infinite no start");
		check(ht, 1'b0, "infinite no trip");
		field.drive_current(16'h0000);
		$display("range test done");

		set_lvl(8'h64, 8'h14, 7'h06, 7'h05);
		set_sw(8'h81, 4'h0, 8'h00);
		field.drive_current(16'h00FF);
		wait_trip(1'b0, 59 * TICK, 60 * TICK + 6);
		field.drive_current(16'h0000);
		cyc(2);
		field.drive_current(16'h00FF);
		wait_trip(1'b1, 49 * TICK, 50 * TICK + 6);
		field.drive_current(16'h0000);
		$display("long time test done");
		print_verdict();
	end
endmodule
